// File: ppi_pkg.sv
// Package with constants and types for the parallel pixel input port
package ppi_pkg;
  // Register byte offsets
  localparam logic [4:0] PPI_CTRL_OFS = 5'h00;
  localparam logic [4:0] PPI_HWIN_OFS = 5'h04;
  localparam logic [4:0] PPI_VWIN_OFS = 5'h08;
  localparam logic [4:0] PPI_FRMCNT_OFS = 5'h0c;
  localparam logic [4:0] PPI_PATCNT_OFS = 5'h10;
  // Window field positions (start in low half, length in high half)
  localparam int PPI_WIN_START_LSB = 0;
  localparam int PPI_WIN_LEN_LSB = 16;
  localparam int PPI_WIN_W = 12;
  // Reset values
  localparam logic [31:0] PPI_CTRL_RST = 32'h0000_0008;
  localparam logic [31:0] PPI_HWIN_RST = 32'h0356_0004;
  localparam logic [31:0] PPI_VWIN_RST = 32'h01e0_0002;
  // Largest image formed for the mirror array
  localparam logic [11:0] PPI_DMD_COLS = 12'h356;
  localparam logic [11:0] PPI_DMD_ROWS = 12'h1e0;
  // Binary patterns carried by one frame
  localparam logic [31:0] PPI_PAT_PER_FRM_24 = 32'h0000_0018;
  localparam logic [31:0] PPI_PAT_PER_FRM_16 = 32'h0000_0010;
  // AXI responses
  localparam logic [1:0] PPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPI_RESP_SLVERR = 2'h2;
  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [20:0] unused;     // Stored and read back as written, zero after reset
    logic [1:0] beats_m1;    // Pixel clock transfers per pixel minus one
    logic hold_pol_low;      // Frame hold mask active low
    logic src_flash;         // Take pixels from the flash path
    logic proc_en;           // Image processing enable
    logic pattern_mode;      // Pattern generation mode
    logic fmt16;             // 16-bit 5-6-5 transfer format
    logic use_strobe;        // Pixel valid strobe used for framing
    logic hs_pol_low;        // Line sync active low
    logic vs_pol_low;        // Frame sync active low
    logic cap_fall;          // Capture on falling pixel clock edge
  } ppi_ctrl_s;
  // One captured sample of the source-synchronous pins
  typedef struct packed {
    logic hs;                // Line sync
    logic de;                // Pixel valid strobe
    logic [23:0] data;       // Pixel bus
  } ppi_cap_s;
endpackage : ppi_pkg

// File: ppi_top.sv
// Parallel pixel input port with AXI4-Lite control registers
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] Capture edge selectable, rising after reset
// [RULE_02] 24-bit format carries 8-8-8 RGB
// [RULE_03] 16-bit format carries 5-6-5 RGB
// [RULE_04] Pixel may span several clock transfers
// [RULE_05] Controller sets sequencer sync to automatic
// [RULE_06] Output image limited to 854 by 480
// [RULE_07] Source select, optional processing, then formatting
// [RULE_08] Pattern mode maps pixel bits one-to-one
// [RULE_09] Pattern rates follow 24 or 16 bits
// [RULE_10] Frame and line sync polarity programmable
// [RULE_11] Auto window from counts without strobe
// [RULE_12] Frame hold mask blocks image, programmable level
// [RULE_13] Source keeps frame sync running continuously
// [RULE_14] Sync, strobe and bus captured together; frame sync is sampled apart, on the rising edge only
module ppi_top
  import ppi_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_clk,
  input wire logic frame_sync,
  input wire logic line_sync,
  input wire logic pixel_valid_strobe,
  input wire logic [DATA_W-1:0] pixel_data,
  input wire logic frame_hold_mask,
  input wire logic [DATA_W-1:0] flash_pix_data,
  input wire logic flash_pix_valid,
  output logic [DATA_W-1:0] out_pix_data,
  output logic out_pix_valid,
  output logic out_pix_sof
);

  // Write-merge of one 32-bit register under byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---- AXI4-Lite slave, aclk domain ----
  logic aw_got_ff; // Write address held
  logic w_got_ff; // Write data held
  logic [4:0] awaddr_ff; // Latched write address
  logic [31:0] wdata_ff; // Latched write data
  logic [3:0] wstrb_ff; // Latched byte strobes
  logic bvalid_ff; // Write response pending
  logic [1:0] bresp_ff; // Write response code
  logic rvalid_ff; // Read data pending
  logic [31:0] rdata_ff; // Read data
  logic [1:0] rresp_ff; // Read response code
  logic [31:0] ctrl_ff; // Control register
  logic [31:0] hwin_ff; // Horizontal window register
  logic [31:0] vwin_ff; // Vertical window register
  logic [31:0] frm_cnt_ff; // Frames seen
  logic [31:0] pat_cnt_ff; // Binary patterns received
  logic do_write; // Both write halves present

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  // Capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= PPI_CTRL_RST;
      hwin_ff <= PPI_HWIN_RST;
      vwin_ff <= PPI_VWIN_RST;
      bvalid_ff <= 1'b0;
      bresp_ff <= PPI_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= PPI_RESP_OKAY;
      unique case (awaddr_ff)
        PPI_CTRL_OFS: ctrl_ff <= wmerge(ctrl_ff, wdata_ff, wstrb_ff);
        PPI_HWIN_OFS: hwin_ff <= wmerge(hwin_ff, wdata_ff, wstrb_ff);
        PPI_VWIN_OFS: vwin_ff <= wmerge(vwin_ff, wdata_ff, wstrb_ff);
        PPI_FRMCNT_OFS, PPI_PATCNT_OFS: bresp_ff <= PPI_RESP_OKAY;
        default: bresp_ff <= PPI_RESP_SLVERR; // Unmapped address
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= PPI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= PPI_RESP_OKAY;
      unique case (s_axi_araddr)
        PPI_CTRL_OFS: rdata_ff <= ctrl_ff;
        PPI_HWIN_OFS: rdata_ff <= hwin_ff;
        PPI_VWIN_OFS: rdata_ff <= vwin_ff;
        PPI_FRMCNT_OFS: rdata_ff <= frm_cnt_ff;
        PPI_PATCNT_OFS: rdata_ff <= pat_cnt_ff;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= PPI_RESP_SLVERR; // Unmapped address
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---- Crossing into the pixel clock domain ----
  logic rstn_meta_ff; // Reset synchroniser, first stage
  logic prstn_ff; // Pixel-domain reset, active low
  logic cfg_tgl_ff; // Flips after every register write
  logic [2:0] cfg_sync_ff; // Write notice synchroniser and edge stage
  logic [95:0] cfg_ff; // Configuration copy in the pixel domain
  ppi_ctrl_s pc; // Control fields in the pixel domain
  logic [11:0] h_start, h_len, v_start, v_len; // Auto window

  // Reset synchroniser into the pixel domain
  always_ff @(posedge pix_clk) begin
    rstn_meta_ff <= aresetn;
    prstn_ff <= rstn_meta_ff;
  end

  // Announce each register write to the pixel domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_tgl_ff <= 1'b0;
    end else if (do_write) begin
      cfg_tgl_ff <= !cfg_tgl_ff;
    end
  end

  // Copy the registers only once the notice has crossed; they are
  // stable by then, so no bit of the word is caught mid-change
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff) begin
      cfg_sync_ff <= 3'h0;
      cfg_ff <= {PPI_CTRL_RST, PPI_HWIN_RST, PPI_VWIN_RST};
    end else begin
      cfg_sync_ff <= {cfg_sync_ff[1:0], cfg_tgl_ff};
      if (cfg_sync_ff[2] ^ cfg_sync_ff[1]) begin
        cfg_ff <= {ctrl_ff, hwin_ff, vwin_ff};
      end
    end
  end
  assign pc = ppi_ctrl_s'(cfg_ff[95:64]);
  assign h_start = cfg_ff[32+PPI_WIN_START_LSB +: PPI_WIN_W];
  assign h_len = cfg_ff[32+PPI_WIN_LEN_LSB +: PPI_WIN_W];
  assign v_start = cfg_ff[PPI_WIN_START_LSB +: PPI_WIN_W];
  assign v_len = cfg_ff[PPI_WIN_LEN_LSB +: PPI_WIN_W];

  // ---- Line sync, strobe and bus captured on both edges, then selection ----
  ppi_cap_s cap_r_ff; // Sampled on rising edge
  ppi_cap_s cap_f_ff; // Sampled on falling edge
  ppi_cap_s cap_ff; // Selected sample, rising-edge timed
  logic vs_ff, hold_ff; // Frame sync and hold mask samples
  logic hs_prev_ff, vs_prev_ff; // Previous active sync levels
  logic hs_act, vs_act, hs_lead, vs_lead; // Active levels, leading edges

  // Rising-edge sample of line sync, strobe and bus together
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff) begin
      cap_r_ff <= '0;
    end else begin
      cap_r_ff <= {line_sync, pixel_valid_strobe, pixel_data}; // RULE_14
    end
  end

  // Falling-edge sample of the same group
  always_ff @(negedge pix_clk) begin
    if (!prstn_ff) begin
      cap_f_ff <= '0;
    end else begin
      cap_f_ff <= {line_sync, pixel_valid_strobe, pixel_data}; // RULE_14
    end
  end

  // Pick the programmed capture edge; rising after reset
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff) begin
      cap_ff <= '0;
      vs_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      cap_ff <= pc.cap_fall ? cap_f_ff : cap_r_ff; // RULE_01
      vs_ff <= frame_sync;
      hold_ff <= frame_hold_mask;
    end
  end

  assign hs_act = cap_ff.hs ^ pc.hs_pol_low; // RULE_10
  assign vs_act = vs_ff ^ pc.vs_pol_low; // RULE_10
  assign hs_lead = hs_act && !hs_prev_ff;
  assign vs_lead = vs_act && !vs_prev_ff;

  // ---- Sync counters and auto window ----
  logic [11:0] h_cnt_ff, v_cnt_ff; // Position since syncs
  logic de_auto, de; // Derived and chosen valid window
  logic hold_lat_ff; // Hold mask latched in vertical blanking

  // Count pixels from line sync and lines from frame sync
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff) begin
      hs_prev_ff <= 1'b0;
      vs_prev_ff <= 1'b0;
      h_cnt_ff <= 12'h000;
      v_cnt_ff <= 12'h000;
      hold_lat_ff <= 1'b0;
    end else begin
      hs_prev_ff <= hs_act;
      vs_prev_ff <= vs_act;
      h_cnt_ff <= hs_lead ? 12'h000 : h_cnt_ff + 12'h001;
      if (vs_lead) begin
        v_cnt_ff <= 12'h000;
        hold_lat_ff <= hold_ff ^ pc.hold_pol_low; // RULE_12
      end else if (hs_lead) begin
        v_cnt_ff <= v_cnt_ff + 12'h001;
      end
    end
  end

  assign de_auto = (h_cnt_ff >= h_start) && // RULE_11
    ({1'b0, h_cnt_ff} < {1'b0, h_start} + {1'b0, h_len}) &&
    (v_cnt_ff >= v_start) &&
    ({1'b0, v_cnt_ff} < {1'b0, v_start} + {1'b0, v_len});
  assign de = pc.use_strobe ? cap_ff.de : de_auto; // RULE_11

  // ---- Pixel assembly over several transfers ----
  logic [1:0] beat_ff; // Transfer index within a pixel
  logic [23:0] acc_ff; // Assembly shift register
  logic [23:0] nxt_acc; // Shift register with this transfer
  logic px_rdy; // Whole pixel present this cycle
  logic [23:0] px_raw; // Assembled source pixel

  assign nxt_acc = {acc_ff[15:0], cap_ff.data[7:0]}; // RULE_04
  assign px_rdy = de && (beat_ff == pc.beats_m1); // RULE_04
  assign px_raw = (pc.beats_m1 == 2'h0) ? cap_ff.data : nxt_acc;

  // Shift eight lines per transfer until the pixel is complete
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff || hs_lead) begin
      beat_ff <= 2'h0;
      acc_ff <= 24'h00_0000;
    end else if (de) begin
      acc_ff <= nxt_acc; // RULE_04
      beat_ff <= px_rdy ? 2'h0 : beat_ff + 2'h1;
    end
  end

  // ---- Source select, processing, formatting ----
  logic [23:0] src_pix; // Pixel from the chosen source
  logic src_vld; // Its valid
  logic [23:0] fmt_pix; // Formatted pixel
  logic [11:0] col_ff, row_ff; // Output position
  logic line_used_ff; // Current line carried pixels
  logic in_crop; // Inside the mirror array

  assign src_pix = pc.src_flash ? flash_pix_data : px_raw; // RULE_07
  assign src_vld = pc.src_flash ? flash_pix_valid : px_rdy; // RULE_07

  // Format one pixel for the mirror array
  always_comb begin
    if (pc.pattern_mode) begin
      // Bits pass straight to their mirrors
      fmt_pix = pc.fmt16 ? {8'h00, src_pix[15:0]} : src_pix; // RULE_08
    end else if (pc.proc_en && pc.fmt16) begin
      // Widen 5-6-5 to 8-8-8 by replicating top bits
      fmt_pix = {src_pix[15:11], src_pix[15:13], // RULE_03
                 src_pix[10:5], src_pix[10:9],
                 src_pix[4:0], src_pix[4:2]};
    end else if (pc.fmt16) begin
      fmt_pix = {8'h00, src_pix[15:0]}; // RULE_03
    end else begin
      fmt_pix = src_pix; // RULE_02
    end
  end

  assign in_crop = (col_ff < PPI_DMD_COLS) && (row_ff < PPI_DMD_ROWS);

  // Track position and drive the registered pixel stream
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff || vs_lead) begin
      col_ff <= 12'h000;
      row_ff <= 12'h000;
      line_used_ff <= 1'b0;
      out_pix_valid <= 1'b0;
      out_pix_sof <= 1'b0;
      out_pix_data <= '0;
    end else begin
      if (hs_lead) begin
        col_ff <= 12'h000;
        line_used_ff <= 1'b0;
        if (line_used_ff) begin
          row_ff <= row_ff + 12'h001;
        end
      end else if (src_vld) begin
        line_used_ff <= 1'b1;
        if (col_ff != 12'hfff) begin
          col_ff <= col_ff + 12'h001;
        end
      end
      // Held frames and pixels past the array never leave
      out_pix_valid <= src_vld && !hs_lead && in_crop && // RULE_06
                       !hold_lat_ff; // RULE_12
      out_pix_sof <= src_vld && !hs_lead && !hold_lat_ff &&
                     (col_ff == 12'h000) && (row_ff == 12'h000);
      if (src_vld) begin
        out_pix_data <= fmt_pix[DATA_W-1:0];
      end
    end
  end

  // ---- Frame event back to aclk as a toggle ----
  logic frm_tgl_ff; // Toggles at each frame sync
  logic [2:0] frm_sync_ff; // Toggle synchroniser and edge stage
  logic frm_pulse; // One aclk pulse per frame
  ppi_ctrl_s ac; // Control fields in the register domain

  assign ac = ppi_ctrl_s'(ctrl_ff);

  // Flip the toggle at every frame start
  always_ff @(posedge pix_clk) begin
    if (!prstn_ff) begin
      frm_tgl_ff <= 1'b0;
    end else if (vs_lead) begin
      frm_tgl_ff <= !frm_tgl_ff;
    end
  end

  // Two stages, then a third for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_sync_ff <= 3'h0;
    end else begin
      frm_sync_ff <= {frm_sync_ff[1:0], frm_tgl_ff};
    end
  end
  assign frm_pulse = frm_sync_ff[2] ^ frm_sync_ff[1];

  // Count frames and binary patterns received
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_cnt_ff <= 32'h0000_0000;
      pat_cnt_ff <= 32'h0000_0000;
    end else if (frm_pulse) begin
      frm_cnt_ff <= frm_cnt_ff + 32'h0000_0001;
      if (ac.pattern_mode) begin
        pat_cnt_ff <= pat_cnt_ff + (ac.fmt16 ? // RULE_09
                      PPI_PAT_PER_FRM_16 : PPI_PAT_PER_FRM_24);
      end
    end
  end

  // ---- Assertions ----
  crop_cols_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_06
    out_pix_valid |-> $past(col_ff) < PPI_DMD_COLS)
    else $error("pixel passed beyond last mirror column");

  crop_rows_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_06
    out_pix_valid |-> $past(row_ff) < PPI_DMD_ROWS)
    else $error("pixel passed beyond last mirror row");

  hold_gate_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_12
    hold_lat_ff && !vs_lead |=> !out_pix_valid)
    else $error("pixel shown while frame hold active");

  expand_565_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_03
    $past(src_vld && pc.proc_en && pc.fmt16 && !pc.pattern_mode)
    && out_pix_valid |-> out_pix_data[18:16] == out_pix_data[23:21])
    else $error("5-6-5 red not widened correctly");

  pattern_raw_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_08
    $past(src_vld && pc.pattern_mode && !pc.src_flash && pc.fmt16 &&
          pc.beats_m1 == 2'h0) && out_pix_valid
    |-> out_pix_data[15:0] == $past(cap_ff.data[15:0]))
    else $error("pattern bits not passed one to one");

  edge_default_a: assert property (@(posedge aclk) // RULE_01
    !$past(aresetn) && aresetn |-> ac.cap_fall == 1'b0)
    else $error("capture edge not rising after reset");

  assembly_a: assert property (@(posedge pix_clk) disable iff (!prstn_ff) // RULE_04
    px_rdy && pc.beats_m1 == 2'h2 && !hs_lead
    |-> $past(de) && $past(de, 2))
    else $error("pixel completed before all transfers");

  pat_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    frm_pulse && ac.pattern_mode && !ac.fmt16
    |=> pat_cnt_ff == $past(pat_cnt_ff) + PPI_PAT_PER_FRM_24)
    else $error("24-bit frame did not add 24 patterns");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");

endmodule // ppi_top

// File: ppi_src_model.sv
// Behavioural pixel source driving frames onto the parallel port
`timescale 1ns/1ns
module ppi_src_model (
  input wire logic pix_clk,
  input wire logic cap_fall,
  input wire logic vs_low,
  input wire logic hs_low,
  output logic frame_sync,
  output logic line_sync,
  output logic pixel_valid_strobe,
  output logic [23:0] pixel_data
);
  logic vs_raw = 1'b0; // Frame sync before polarity
  logic hs_raw = 1'b0; // Line sync before polarity
  logic [23:0] seed = 24'h0; // Pixel pattern of this frame
  assign frame_sync = vs_raw ^ vs_low;
  assign line_sync = hs_raw ^ hs_low;
  initial pixel_valid_strobe = 1'b0;
  initial pixel_data = 24'h0;
  // Value of transfer k in line r
  function automatic logic [23:0] px(logic [23:0] s, int k, int r);
    return 24'(s ^ (k * 24'h09e37b) ^ (r << 12));
  endfunction
  // Launch on the edge opposite to capture, so setup and hold are wide
  task automatic step();
    if (cap_fall) @(posedge pix_clk);
    else @(negedge pix_clk);
  endtask
  // Sync pulse 4, back porch 4, w transfers, front porch 8
  task automatic line(input int w, input int r, input bit de);
    for (int h = 0; h < w + 16; h++) begin
      step();
      hs_raw <= (h < 4);
      pixel_valid_strobe <= de && h >= 8 && h < w + 8;
      // Idle bus toggles so stale data never looks valid
      if (h >= 8 && h < w + 8) pixel_data <= px(seed, h - 8, r);
      else pixel_data <= ~pixel_data;
    end
  endtask
  // Sync line, two blank lines, active lines, one blank line
  task automatic frame(input int nl, w0, w, wb, input bit de,
                       input logic [23:0] sd);
    seed = sd;
    step();
    vs_raw <= 1'b1;
    line(wb, 0, 1'b0);
    vs_raw <= 1'b0;
    repeat (2) line(wb, 0, 1'b0);
    for (int r = 0; r < nl; r++) line(r == 0 ? w0 : w, r, de);
    line(wb, 0, 1'b0);
  endtask
endmodule // ppi_src_model

// File: parallel_pattern_pixel_input_tb.sv
// Self-checking bench for the parallel pixel input port
`timescale 1ns/1ns
module parallel_pattern_pixel_input_tb
  import ppi_pkg::*;
;
  logic aclk = 1'b0; // Register clock
  logic pix_clk = 1'b0; // Link clock
  logic aresetn = 1'b0; // Reset, active low
  logic [4:0] awaddr = 5'h0, araddr = 5'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, hold = 1'b0, fl_v = 1'b0;
  logic cfall = 1'b0, vlo = 1'b0, hlo = 1'b0; // Source launch setup
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] fl_d = 24'h0, pd, od, sd;
  logic [23:0] fl_q = 24'h0; // Flash pixel the design saw last edge
  bit fchk = 1'b0; // Compare output against the flash path
  logic awready, wready, bvalid, arready, rvalid, fs, hs, de, ov, osof;
  logic [1:0] bresp, rresp;
  int failures = 0, n_checks = 0, nsof = 0, w, nl;
  logic [23:0] got[$]; // Output pixels of the last frame
  initial forever #20 aclk = ~aclk;
  initial #7 forever #16 pix_clk = ~pix_clk;
  ppi_top DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .pix_clk(pix_clk),
    .frame_sync(fs),
    .line_sync(hs),
    .pixel_valid_strobe(de),
    .pixel_data(pd),
    .frame_hold_mask(hold),
    .flash_pix_data(fl_d),
    .flash_pix_valid(fl_v),
    .out_pix_data(od),
    .out_pix_valid(ov),
    .out_pix_sof(osof)
  );
  ppi_src_model src (
    .pix_clk(pix_clk),
    .cap_fall(cfall),
    .vs_low(vlo),
    .hs_low(hlo),
    .frame_sync(fs),
    .line_sync(hs),
    .pixel_valid_strobe(de),
    .pixel_data(pd)
  );
  // Collect output pixels; random data on the flash path
  always @(posedge pix_clk) begin
    if (ov === 1'b1) got.push_back(od);
    if (osof === 1'b1) nsof++;
    // A flash pixel leaves two edges after it is offered
    if (fchk && ov === 1'b1) chk(32'(od), 32'(fl_q));
    fl_q <= fl_d;
    fl_d <= 24'($urandom());
    fl_v <= 1'($urandom());
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // AXI write: address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  // AXI read with expected data and response
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  // Program control, then match the source to edge and polarity
  task automatic setc(input logic [31:0] c);
    wr(PPI_CTRL_OFS, c, PPI_RESP_OKAY);
    repeat (4) @(posedge pix_clk);
    cfall <= c[0];
    vlo <= c[1];
    hlo <= c[2];
    repeat (6) @(posedge pix_clk);
  endtask
  task automatic run(input int n, w0, w1, wb, input bit d);
    got.delete();
    nsof = 0;
    src.frame(n, w0, w1, wb, d, sd);
    repeat (10) @(posedge pix_clk);
  endtask
  function automatic logic [23:0] px(logic [23:0] s, int k, int r);
    return 24'(s ^ (k * 24'h09e37b) ^ (r << 12));
  endfunction
  // Expected pixel: 0 raw, 1 plain 16-bit, 2 widened 16-bit, 3 byte beats
  function automatic logic [23:0] ex(int m, int k, int r);
    logic [23:0] v;
    logic [7:0] a, b, c;
    v = px(sd, k, r);
    a = 8'(px(sd, 3 * k, r));
    b = 8'(px(sd, 3 * k + 1, r));
    c = 8'(px(sd, 3 * k + 2, r));
    case (m)
      1: return {8'h00, v[15:0]};
      2: return {v[15:11], v[15:13], v[10:5], v[10:9], v[4:0], v[4:2]};
      3: return {a, b, c};
      default: return v;
    endcase
  endfunction
  task automatic cmpf(input int m);
    chk(32'(got.size()), 32'(nl * w));
    chk(32'(nsof), 32'h1);
    foreach (got[i]) chk(32'(got[i]), 32'(ex(m, i % w, i / w)));
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sd = 24'($urandom(992));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge pix_clk);
    rd(PPI_CTRL_OFS, PPI_CTRL_RST, PPI_RESP_OKAY);
    rd(PPI_HWIN_OFS, PPI_HWIN_RST, PPI_RESP_OKAY);
    rd(PPI_VWIN_OFS, PPI_VWIN_RST, PPI_RESP_OKAY);
    rd(5'h14, 32'h0, PPI_RESP_SLVERR);
    wr(5'h14, 32'h1, PPI_RESP_SLVERR);
    wr(PPI_FRMCNT_OFS, 32'h5, PPI_RESP_OKAY);
    rd(PPI_FRMCNT_OFS, 32'h0, PPI_RESP_OKAY);
    // Random frames, default setup and inverted edge and syncs in turn
    for (int t = 0; t < 4; t++) begin
      setc(t[0] ? 32'h0000_000f : 32'h0000_0008);
      w = 2 + $urandom_range(6);
      nl = 1 + $urandom_range(2);
      sd = 24'($urandom());
      run(nl, w, w, 0, 1'b1);
      cmpf(0);
      if (t == 0) rd(PPI_FRMCNT_OFS, 32'h1, PPI_RESP_OKAY);
    end
    w = 4;
    nl = 2;
    setc(32'h0000_0018);
    run(2, 4, 4, 0, 1'b1);
    cmpf(1);
    setc(32'h0000_0058);
    run(2, 4, 4, 0, 1'b1);
    cmpf(2);
    setc(32'h0000_0408);
    run(2, 12, 12, 0, 1'b1);
    cmpf(3);
    setc(32'h0000_0028);
    run(2, 4, 4, 0, 1'b1);
    cmpf(0);
    rd(PPI_PATCNT_OFS, PPI_PAT_PER_FRM_24, PPI_RESP_OKAY);
    setc(32'h0000_0038);
    run(2, 4, 4, 0, 1'b1);
    chk(32'(got.size()), 32'h8);
    rd(PPI_PATCNT_OFS, PPI_PAT_PER_FRM_24 + PPI_PAT_PER_FRM_16,
       PPI_RESP_OKAY);
    // Flash path as source, compared pixel by pixel above
    setc(32'h0000_0088);
    fchk = 1'b1;
    run(2, 4, 4, 0, 1'b1);
    fchk = 1'b0;
    chk(32'(got.size() != 0), 32'h1);
    // Hold mask raised in blanking, then its level inverted
    setc(32'h0000_0008);
    @(posedge pix_clk) hold <= 1'b1;
    run(2, 4, 4, 0, 1'b1);
    chk(32'(got.size()), 32'h0);
    setc(32'h0000_0108);
    run(2, 4, 4, 0, 1'b1);
    cmpf(0);
    @(posedge pix_clk) hold <= 1'b0;
    // Oversized frame is cut to the mirror array
    setc(32'h0000_0008);
    run(482, 860, 1, 0, 1'b1);
    chk(32'(got.size()), 32'(PPI_DMD_COLS + PPI_DMD_ROWS - 1));
    chk(32'(got[853]), 32'(px(sd, 853, 0)));
    chk(32'(got[854]), 32'(px(sd, 0, 1)));
    // Window from counts, strobe ignored
    wr(PPI_HWIN_OFS, 32'h0006_0008, PPI_RESP_OKAY);
    wr(PPI_VWIN_OFS, 32'h0003_0002, PPI_RESP_OKAY);
    setc(32'h0000_0000);
    run(6, 16, 16, 16, 1'b0);
    chk(32'(got.size()), 32'h12);
    chk(32'(nsof), 32'h1);
    test_done();
  end
  // Cut a hang short well beyond the expected run time
  initial begin
    #1000000;
    failures++;
    test_done();
  end
endmodule // parallel_pattern_pixel_input_tb
